/* File: slcr_consts.svh */
`ifndef SLCR_CONSTS_SVH
`define SLCR_CONSTS_SVH

// ==========================================================
// serial frame layout
`define SLCR_CNT_CMD_LAST 5'h0F
`define SLCR_CNT_FRAME_LAST 5'h17
`define SLCR_CNT_ZERO 5'h00
`define SLCR_CNT_STEP 5'h01
`define SLCR_CMD_RW_BIT 4'hE
`define SLCR_CMD_ADDR_HI 4'hD
`define SLCR_DATA_HI 3'h6
`define SLCR_READ_CODE 1'h1
`define SLCR_DATA_ZERO 8'h00

// ==========================================================
// register offsets
`define SLCR_ADDR_BLEED 15'h002A
`define SLCR_ADDR_MOD 15'h002B
`define SLCR_ADDR_CORE_D 15'h002C
`define SLCR_ADDR_CORE_C 15'h002D
`define SLCR_ADDR_CORE_B 15'h002E
`define SLCR_ADDR_FINE 15'h0010

// ==========================================================
// reset values and writable bits
`define SLCR_RST_BLEED 8'h00
`define SLCR_RST_MOD 8'h01
`define SLCR_RST_CORE_D 8'h44
`define SLCR_RST_CORE_C 8'h11
`define SLCR_RST_CORE_B 8'h12
`define SLCR_MASK_BLEED 8'h29
`define SLCR_MASK_MOD 8'h35
`define SLCR_MASK_CORE_D 8'h7F
`define SLCR_MASK_CORE_CB 8'h1F

// ==========================================================
// field positions
`define SLCR_BIT_BLEED_POLARITY_SEL 3'h5
`define SLCR_BIT_RESYNC 3'h3
`define SLCR_BIT_READ_SEL 3'h0
`define SLCR_BIT_HALF_STEP 3'h5
`define SLCR_BIT_AUX_MOD 3'h4
`define SLCR_BIT_RST_MASK 3'h2
`define SLCR_BIT_MOD_DIS 3'h0
`define SLCR_BIT_AMP_OFF 3'h0
`define SLCR_BIT_TEMP_CAL 3'h1
`define SLCR_CORED_RECT 3'h6
`define SLCR_CORED_RANGE 3'h5
`define SLCR_CORED_NOM_HI 3'h4
`define SLCR_CORED_NOM_LO 3'h2
`define SLCR_CORECB_RECT 3'h4
`define SLCR_CORECB_RANGE 3'h3
`define SLCR_CORECB_NOM_HI 3'h2
`define SLCR_CORECB_NOM_LO 3'h0

`endif

/* File: slcr_pkg.sv */
`default_nettype none
package slcr_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_HOLD} slcr_state_e;

    typedef struct packed {
        logic rectifier_bias;
        logic threshold_range;
        logic [2:0] nominal_threshold;
    } slcr_core_cfg_s;

    typedef logic [7:0] slcr_byte_t;
endpackage
`default_nettype wire

/* File: slcr_cfg_byte.sv */
`timescale 1ns/1ps
`default_nettype none
module slcr_cfg_byte
    import slcr_pkg::*;
#(
    parameter slcr_byte_t RESET_VAL = 8'h00,
    parameter slcr_byte_t WR_MASK = 8'hFF
)
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic wr_en,
    input wire slcr_byte_t wr_data,
    output slcr_byte_t q
);
    // ==========================================================
    // one configuration byte, reserved bits held at zero
    slcr_byte_t q_reg;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            q_reg <= RESET_VAL;
        else if (wr_en)
            q_reg <= wr_data & WR_MASK; // RL19
    end

    assign q = q_reg;

    // ==========================================================
    // checks
    reserved_zero_a: assert property ( // RL19
        @(posedge clk) disable iff (!resetn)
        wr_en |=> ((q & ~WR_MASK) == 8'h00) && (q == ($past(wr_data) & WR_MASK))
    ) else $error("reserved bit set or write lost");
endmodule
`default_nettype wire

/* File: slcr_top.sv */
// What this block does
// (RL1) bit 5 of 0x2A selects bleed polarity, 0 negative, 1 positive
// (RL2) bit 3 of 0x2A makes frame load wait for a reference edge
// (RL3) bit 0 of 0x2A selects readback source: 0 VCO data, 1 version
// (RL4) bit 5 of 0x2B adds half step when auxiliary modulator is off
// (RL5) bit 4 of 0x2B enables auxiliary modulator, resets to 0
// (RL6) bit 2 of 0x2B masks modulator reset on fine register 0x10 update
// (RL7) software sets bit 0 of 0x2B in integer mode, clears it otherwise
// (RL8) bit 0 of 0x2C disables amplitude loop; reset keeps it enabled
// (RL9) bit 1 of 0x2C enables temperature dependent calibration voltage
// (RL10) bit 6 of 0x2C picks core D rectifier bias, resets to 1
// (RL11) bit 5 of 0x2C picks core D threshold range
// (RL12) bits 4:2 of 0x2C hold core D nominal threshold
// (RL13) bit 4 of 0x2D picks core C rectifier bias, resets to 1
// (RL14) bit 3 of 0x2D picks core C threshold range
// (RL15) bits 2:0 of 0x2D hold core C nominal threshold
// (RL16) bit 4 of 0x2E picks core B rectifier bias
// (RL17) bit 3 of 0x2E picks core B threshold range
// (RL18) bits 2:0 of 0x2E hold core B nominal threshold, reset 0x2
// (RL19) reserved bits read zero and ignore writes
`timescale 1ns/1ps
`default_nettype none
`include "slcr_consts.svh"
module slcr_top
    import slcr_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic RESETN,
    input wire logic SER_CLK,
    input wire logic SER_DATA_IN,
    output logic SER_DATA_OUT,
    output logic SER_DATA_OE_N,
    input wire logic CHIP_SELECT_PIN_N,
    input wire logic REFERENCE_INPUT_NEG,
    output logic LOAD_STROBE,
    output logic MOD_RESET_PULSE,
    output logic BLEED_POLARITY_SEL,
    output logic CHIP_SELECT_RESYNC_EN,
    output logic READBACK_VERSION_SEL,
    output logic HALF_STEP_ADD,
    output logic AUX_MODULATOR_EN,
    output logic MODULATOR_RESET_MASK,
    output logic MODULATOR_DISABLE,
    output logic AMPLITUDE_LOOP_OFF,
    output logic TEMP_CAL_VOLTAGE_EN,
    output slcr_core_cfg_s CORE_D_CFG,
    output slcr_core_cfg_s CORE_C_CFG,
    output slcr_core_cfg_s CORE_B_CFG
);

    // ==========================================================
    // pin edge detection
    logic sclk_d_reg;
    logic cs_d_reg;
    logic ref_d_reg;

    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            sclk_d_reg <= 1'h0;
            cs_d_reg <= 1'h1;
            ref_d_reg <= 1'h0;
        end
        else
        begin
            sclk_d_reg <= SER_CLK;
            cs_d_reg <= CHIP_SELECT_PIN_N;
            ref_d_reg <= REFERENCE_INPUT_NEG;
        end
    end

    wire cs_active = ~CHIP_SELECT_PIN_N;
    wire sclk_rise = SER_CLK & ~sclk_d_reg;
    wire sclk_fall = ~SER_CLK & sclk_d_reg;
    wire cs_fall = ~CHIP_SELECT_PIN_N & cs_d_reg;
    wire cs_rise = CHIP_SELECT_PIN_N & ~cs_d_reg;
    wire ref_rise = REFERENCE_INPUT_NEG & ~ref_d_reg;

    // ==========================================================
    // frame state
    slcr_state_e state_reg;
    slcr_state_e state_next;
    logic [4:0] bit_cnt_reg;
    logic [4:0] bit_cnt_next;
    logic [22:0] shift_in_reg;
    logic cmd_read_reg;
    logic [14:0] cmd_addr_reg;

    wire bit_rise = (state_reg == ST_SHIFT) & sclk_rise & cs_active;
    wire cmd_rise = bit_rise & (bit_cnt_reg == `SLCR_CNT_CMD_LAST);
    wire last_rise = bit_rise & (bit_cnt_reg == `SLCR_CNT_FRAME_LAST);
    wire frame_start = (state_reg == ST_IDLE) & cs_fall;

    wire cmd_read_wire = (shift_in_reg[`SLCR_CMD_RW_BIT] == `SLCR_READ_CODE);
    wire [14:0] cmd_addr_wire = {shift_in_reg[`SLCR_CMD_ADDR_HI:0], SER_DATA_IN};
    wire slcr_byte_t wr_data = {shift_in_reg[`SLCR_DATA_HI:0], SER_DATA_IN};

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE:
                if (cs_fall)
                    state_next = ST_SHIFT;
            ST_SHIFT:
                if (!cs_active)
                    state_next = ST_IDLE;
                else if (last_rise)
                    state_next = ST_HOLD;
            ST_HOLD:
                if (!cs_active)
                    state_next = ST_IDLE;
            default:
                state_next = ST_IDLE;
        endcase
    end

    // extra clocks after the data byte are ignored until deselect
    always_comb
    begin
        bit_cnt_next = bit_cnt_reg;
        if (frame_start)
            bit_cnt_next = `SLCR_CNT_ZERO;
        else if (bit_rise)
            bit_cnt_next = bit_cnt_reg + `SLCR_CNT_STEP;
    end

    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            state_reg <= ST_IDLE;
            bit_cnt_reg <= `SLCR_CNT_ZERO;
        end
        else
        begin
            state_reg <= state_next;
            bit_cnt_reg <= bit_cnt_next;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
        if (!RESETN)
            shift_in_reg <= 23'h000000;
        else if (bit_rise)
            shift_in_reg <= {shift_in_reg[21:0], SER_DATA_IN};
    end

    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            cmd_read_reg <= 1'h0;
            cmd_addr_reg <= 15'h0000;
        end
        else if (cmd_rise)
        begin
            cmd_read_reg <= cmd_read_wire;
            cmd_addr_reg <= cmd_addr_wire;
        end
    end

    // ==========================================================
    // write decode
    wire commit = last_rise & ~cmd_read_reg;
    wire wr_bleed = commit & (cmd_addr_reg == `SLCR_ADDR_BLEED);
    wire wr_mod = commit & (cmd_addr_reg == `SLCR_ADDR_MOD);
    wire wr_core_d = commit & (cmd_addr_reg == `SLCR_ADDR_CORE_D);
    wire wr_core_c = commit & (cmd_addr_reg == `SLCR_ADDR_CORE_C);
    wire wr_core_b = commit & (cmd_addr_reg == `SLCR_ADDR_CORE_B);
    wire wr_fine = commit & (cmd_addr_reg == `SLCR_ADDR_FINE);

    // ==========================================================
    // register bytes
    slcr_byte_t q_bleed;
    slcr_byte_t q_mod;
    slcr_byte_t q_core_d;
    slcr_byte_t q_core_c;
    slcr_byte_t q_core_b;

    slcr_cfg_byte #(.RESET_VAL(`SLCR_RST_BLEED), .WR_MASK(`SLCR_MASK_BLEED)) u_bleed
    (
        .clk(SYS_CLK),
        .resetn(RESETN),
        .wr_en(wr_bleed),
        .wr_data(wr_data),
        .q(q_bleed)
    );

    slcr_cfg_byte #(.RESET_VAL(`SLCR_RST_MOD), .WR_MASK(`SLCR_MASK_MOD)) u_mod
    (
        .clk(SYS_CLK),
        .resetn(RESETN),
        .wr_en(wr_mod),
        .wr_data(wr_data),
        .q(q_mod)
    );

    slcr_cfg_byte #(.RESET_VAL(`SLCR_RST_CORE_D), .WR_MASK(`SLCR_MASK_CORE_D)) u_core_d
    (
        .clk(SYS_CLK),
        .resetn(RESETN),
        .wr_en(wr_core_d),
        .wr_data(wr_data),
        .q(q_core_d)
    );

    slcr_cfg_byte #(.RESET_VAL(`SLCR_RST_CORE_C), .WR_MASK(`SLCR_MASK_CORE_CB)) u_core_c
    (
        .clk(SYS_CLK),
        .resetn(RESETN),
        .wr_en(wr_core_c),
        .wr_data(wr_data),
        .q(q_core_c)
    );

    slcr_cfg_byte #(.RESET_VAL(`SLCR_RST_CORE_B), .WR_MASK(`SLCR_MASK_CORE_CB)) u_core_b
    (
        .clk(SYS_CLK),
        .resetn(RESETN),
        .wr_en(wr_core_b),
        .wr_data(wr_data),
        .q(q_core_b)
    );

    // ==========================================================
    // readback
    wire rd_load = cmd_rise & cmd_read_wire;
    wire rd_hit_bleed = (cmd_addr_wire == `SLCR_ADDR_BLEED);
    wire rd_hit_mod = (cmd_addr_wire == `SLCR_ADDR_MOD);
    wire rd_hit_core_d = (cmd_addr_wire == `SLCR_ADDR_CORE_D);
    wire rd_hit_core_c = (cmd_addr_wire == `SLCR_ADDR_CORE_C);
    wire rd_hit_core_b = (cmd_addr_wire == `SLCR_ADDR_CORE_B);
    wire slcr_byte_t rd_data = rd_hit_bleed ? q_bleed :
                               rd_hit_mod ? q_mod :
                               rd_hit_core_d ? q_core_d :
                               rd_hit_core_c ? q_core_c :
                               rd_hit_core_b ? q_core_b : `SLCR_DATA_ZERO;

    slcr_byte_t rd_shift_reg;
    logic rd_out_reg;
    logic rd_drive_reg;

    // data changes on falling serial clock, host samples on rising
    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            rd_shift_reg <= `SLCR_DATA_ZERO;
            rd_out_reg <= 1'h0;
        end
        else if (rd_load)
            rd_shift_reg <= rd_data;
        else if (sclk_fall & rd_drive_reg)
        begin
            rd_out_reg <= rd_shift_reg[7];
            rd_shift_reg <= {rd_shift_reg[6:0], 1'h0};
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
        if (!RESETN)
            rd_drive_reg <= 1'h0;
        else if (!cs_active)
            rd_drive_reg <= 1'h0;
        else if (rd_load)
            rd_drive_reg <= 1'h1;
    end

    assign SER_DATA_OUT = rd_out_reg;
    assign SER_DATA_OE_N = ~rd_drive_reg;

    // ==========================================================
    // frame load and modulator reset
    logic wait_ref_reg;
    logic load_reg;
    logic mod_reset_reg;
    logic fine_pend_reg;
    logic half_step_reg;

    wire resync_en = q_bleed[`SLCR_BIT_RESYNC];
    wire reset_mask = q_mod[`SLCR_BIT_RST_MASK];
    wire load_next = (cs_rise & ~resync_en) | (wait_ref_reg & ref_rise); // RL2
    wire wait_ref_next = (cs_rise & resync_en) | (wait_ref_reg & ~ref_rise); // RL2
    wire fine_pend_next = wr_fine | (fine_pend_reg & ~load_next);
    wire mod_reset_next = load_next & fine_pend_reg & ~reset_mask; // RL6
    wire half_step_next = q_mod[`SLCR_BIT_HALF_STEP] & ~q_mod[`SLCR_BIT_AUX_MOD]; // RL4

    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            wait_ref_reg <= 1'h0;
            load_reg <= 1'h0;
            mod_reset_reg <= 1'h0;
            fine_pend_reg <= 1'h0;
            half_step_reg <= 1'h0;
        end
        else
        begin
            wait_ref_reg <= wait_ref_next;
            load_reg <= load_next;
            mod_reset_reg <= mod_reset_next;
            fine_pend_reg <= fine_pend_next;
            half_step_reg <= half_step_next;
        end
    end

    assign LOAD_STROBE = load_reg;
    assign MOD_RESET_PULSE = mod_reset_reg;
    assign HALF_STEP_ADD = half_step_reg;

    // ==========================================================
    // configuration outputs
    assign BLEED_POLARITY_SEL = q_bleed[`SLCR_BIT_BLEED_POLARITY_SEL]; // RL1
    assign CHIP_SELECT_RESYNC_EN = resync_en; // RL2
    assign READBACK_VERSION_SEL = q_bleed[`SLCR_BIT_READ_SEL]; // RL3
    assign AUX_MODULATOR_EN = q_mod[`SLCR_BIT_AUX_MOD]; // RL5
    assign MODULATOR_RESET_MASK = reset_mask; // RL6
    assign MODULATOR_DISABLE = q_mod[`SLCR_BIT_MOD_DIS];
    assign AMPLITUDE_LOOP_OFF = q_core_d[`SLCR_BIT_AMP_OFF]; // RL8
    assign TEMP_CAL_VOLTAGE_EN = q_core_d[`SLCR_BIT_TEMP_CAL]; // RL9
    assign CORE_D_CFG.rectifier_bias = q_core_d[`SLCR_CORED_RECT]; // RL10
    assign CORE_D_CFG.threshold_range = q_core_d[`SLCR_CORED_RANGE]; // RL11
    assign CORE_D_CFG.nominal_threshold = q_core_d[`SLCR_CORED_NOM_HI:`SLCR_CORED_NOM_LO]; // RL12
    assign CORE_C_CFG.rectifier_bias = q_core_c[`SLCR_CORECB_RECT]; // RL13
    assign CORE_C_CFG.threshold_range = q_core_c[`SLCR_CORECB_RANGE]; // RL14
    assign CORE_C_CFG.nominal_threshold = q_core_c[`SLCR_CORECB_NOM_HI:`SLCR_CORECB_NOM_LO]; // RL15
    assign CORE_B_CFG.rectifier_bias = q_core_b[`SLCR_CORECB_RECT]; // RL16
    assign CORE_B_CFG.threshold_range = q_core_b[`SLCR_CORECB_RANGE]; // RL17
    assign CORE_B_CFG.nominal_threshold = q_core_b[`SLCR_CORECB_NOM_HI:`SLCR_CORECB_NOM_LO]; // RL18

    // ==========================================================
    // checks
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RESETN);

    bleed_polarity_sel_a: assert property ( // RL1
        wr_bleed |=> BLEED_POLARITY_SEL == $past(wr_data[5])
    ) else $error("bleed polarity not taken from write");

    resync_off_a: assert property ( // RL2
        (cs_rise && !CHIP_SELECT_RESYNC_EN) |=> LOAD_STROBE
    ) else $error("load missing after deselect without resync");

    resync_wait_a: assert property ( // RL2
        (cs_rise && CHIP_SELECT_RESYNC_EN && !ref_rise) |=> !LOAD_STROBE
    ) else $error("load did not wait for reference edge");

    read_sel_a: assert property ( // RL3
        wr_bleed |=> READBACK_VERSION_SEL == $past(wr_data[0])
    ) else $error("readback select not taken from write");

    half_step_a: assert property ( // RL4
        $rose(HALF_STEP_ADD) |-> !$past(AUX_MODULATOR_EN)
    ) else $error("half step added while auxiliary modulator on");

    aux_mod_a: assert property ( // RL5
        wr_mod |=> AUX_MODULATOR_EN == $past(wr_data[4]) ##1 $stable(AUX_MODULATOR_EN)
    ) else $error("auxiliary modulator enable wrong");

    mod_reset_a: assert property ( // RL6
        MOD_RESET_PULSE |-> LOAD_STROBE && !$past(MODULATOR_RESET_MASK)
    ) else $error("modulator reset while masked or outside load");

    amp_off_a: assert property ( // RL8
        wr_core_d |=> AMPLITUDE_LOOP_OFF == $past(wr_data[0])
    ) else $error("amplitude loop off bit wrong");

    core_d_a: assert property ( // RL12
        wr_core_d |=> CORE_D_CFG == slcr_core_cfg_s'($past(wr_data[6:2]))
    ) else $error("core D setting wrong");

    core_c_a: assert property ( // RL15
        wr_core_c |=> CORE_C_CFG == slcr_core_cfg_s'($past(wr_data[4:0]))
    ) else $error("core C setting wrong");

    core_b_a: assert property ( // RL18
        wr_core_b |=> CORE_B_CFG == slcr_core_cfg_s'($past(wr_data[4:0]))
    ) else $error("core B setting wrong");

    write_cov: cover property (commit);
    read_cov: cover property (rd_load ##[1:300] !SER_DATA_OE_N);
    resync_cov: cover property (wait_ref_reg && ref_rise ##1 LOAD_STROBE);
    mod_reset_cov: cover property (MOD_RESET_PULSE);
endmodule
`default_nettype wire

/* File: slcr_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module slcr_host_model
    import slcr_pkg::*;
(
    input wire logic sys_clk,
    input wire logic ser_data_out,
    input wire logic ser_data_oe_n,
    output logic ser_clk,
    output logic ser_data_in,
    output logic chip_select_n,
    output slcr_byte_t rd_byte,
    output logic rd_oe_ok,
    output logic rd_done
);
    localparam int HALF = 4;

    initial
    begin
        ser_clk = 1'b0;
        ser_data_in = 1'b0;
        chip_select_n = 1'b1;
        rd_byte = 8'h00;
        rd_oe_ok = 1'b0;
        rd_done = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    // ==========================================================
    // one frame, msb first; fewer than 24 rises cuts it short
    task automatic xfer(input logic rd, input logic [14:0] addr, input slcr_byte_t wd,
                        input int nrise);
        logic [23:0] word;
        slcr_byte_t cap;
        logic ok;
        word = {rd, addr, wd};
        cap = 8'h00;
        ok = 1'b1;
        chip_select_n = 1'b0;
        tick(2);
        for (int i = 23; i >= 24 - nrise; i--)
        begin
            ser_data_in = word[i];
            tick(HALF);
            if (rd && i < 8)
            begin
                cap[i] = ser_data_out;
                ok = ok & (ser_data_oe_n === 1'b0);
            end
            ser_clk = 1'b1;
            tick(HALF);
            ser_clk = 1'b0;
        end
        // released data line shows no stale value
        ser_data_in = ~ser_data_in;
        tick(HALF);
        chip_select_n = 1'b1;
        tick(3);
        if (rd)
        begin
            rd_byte = cap;
            rd_oe_ok = ok & (ser_data_oe_n === 1'b1);
            rd_done = 1'b1;
            tick(1);
            rd_done = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

/* File: synth_loop_config_regs_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module synth_loop_config_regs_tb
    import slcr_pkg::*;
;
    localparam int LIMIT = 40000;
    localparam slcr_byte_t RST_V [5] = '{8'h00, 8'h01, 8'h44, 8'h11, 8'h12};
    localparam slcr_byte_t MSK [5] = '{8'h29, 8'h35, 8'h7F, 8'h1F, 8'h1F};
    localparam slcr_byte_t FIX [4] = '{8'hFF, 8'h00, 8'hAA, 8'h55};

    logic sys_clk, resetn, ser_clk, ser_data_in, ser_data_out, ser_data_oe_n, cs_n;
    logic ref_in, ref_run, ref_clk, ref_lvl, load_strobe, mod_reset_pulse;
    logic bleed_polarity_sel, resync, rdsel, half, aux, rmask, mdis, amp_off, temp;
    slcr_core_cfg_s core_d, core_c, core_b;
    slcr_byte_t rd_byte, v;
    logic rd_oe_ok, rd_done;
    slcr_byte_t img [5];
    slcr_byte_t exp_q [$];
    int err_count, comparisons, strobe_cnt, mreset_cnt, cycles, s0;
    integer seed;

    slcr_top i_slcr_top (.SYS_CLK(sys_clk), .RESETN(resetn), .SER_CLK(ser_clk),
        .SER_DATA_IN(ser_data_in), .SER_DATA_OUT(ser_data_out), .SER_DATA_OE_N(ser_data_oe_n),
        .CHIP_SELECT_PIN_N(cs_n), .REFERENCE_INPUT_NEG(ref_in), .LOAD_STROBE(load_strobe),
        .MOD_RESET_PULSE(mod_reset_pulse), .BLEED_POLARITY_SEL(bleed_polarity_sel),
        .CHIP_SELECT_RESYNC_EN(resync), .READBACK_VERSION_SEL(rdsel), .HALF_STEP_ADD(half),
        .AUX_MODULATOR_EN(aux), .MODULATOR_RESET_MASK(rmask), .MODULATOR_DISABLE(mdis),
        .AMPLITUDE_LOOP_OFF(amp_off), .TEMP_CAL_VOLTAGE_EN(temp), .CORE_D_CFG(core_d),
        .CORE_C_CFG(core_c), .CORE_B_CFG(core_b));

    slcr_host_model i_slcr_host_model (.sys_clk(sys_clk), .ser_data_out(ser_data_out),
        .ser_data_oe_n(ser_data_oe_n), .ser_clk(ser_clk), .ser_data_in(ser_data_in),
        .chip_select_n(cs_n), .rd_byte(rd_byte), .rd_oe_ok(rd_oe_ok), .rd_done(rd_done));

    // ==========================================================
    // clocks
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // reference toggles every third cycle unless held at a level
    initial
    begin
        ref_clk = 1'b0;
        forever
        begin
            repeat (3) @(posedge sys_clk);
            #1 ref_clk = ~ref_clk;
        end
    end

    assign ref_in = ref_run ? ref_clk : ref_lvl;

    // ==========================================================
    // checking helpers
    task automatic test_done();
        $display("errors %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic check_byte(input slcr_byte_t exp, input slcr_byte_t act);
        comparisons++;
        if (act !== exp)
        begin
            err_count++;
            $display("mismatch at %0t: read %h expected %h", $time, act, exp);
        end
    endtask

    task automatic check_vec(input logic [23:0] exp, input logic [23:0] act, input string what);
        comparisons++;
        if (act !== exp)
        begin
            err_count++;
            $display("mismatch at %0t: %s %h expected %h", $time, what, act, exp);
        end
    endtask

    function automatic logic [23:0] exp_cfg();
        return {img[0][5], img[0][3], img[0][0], img[1][5] & ~img[1][4], img[1][4], img[1][2],
                img[1][0], img[2][0], img[2][1], img[2][6:2], img[3][4:0], img[4][4:0]};
    endfunction

    task automatic check_cfg();
        check_vec(exp_cfg(), {bleed_polarity_sel, resync, rdsel, half, aux, rmask, mdis, amp_off, temp,
                              core_d, core_c, core_b}, "config outputs");
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic wr(input logic [14:0] a, input slcr_byte_t d);
        i_slcr_host_model.xfer(1'b0, a, d, 24);
        if (a >= 15'h002A && a <= 15'h002E)
            img[a - 15'h002A] = d & MSK[a - 15'h002A];
        tick(10);
    endtask

    task automatic rd(input logic [14:0] a);
        exp_q.push_back((a >= 15'h002A && a <= 15'h002E) ? img[a - 15'h002A] : 8'h00);
        i_slcr_host_model.xfer(1'b1, a, 8'h00, 24);
        // let a load held for the reference settle before the next count
        tick(10);
    endtask

    // ==========================================================
    // output watcher and hang limit
    always @(posedge sys_clk)
    begin
        if (load_strobe === 1'b1)
            strobe_cnt++;
        if (mod_reset_pulse === 1'b1)
            mreset_cnt++;
        if (rd_done === 1'b1 && exp_q.size() > 0)
        begin
            check_byte(exp_q.pop_front(), rd_byte);
            check_vec(24'h000001, {23'h000000, rd_oe_ok}, "drive enable");
        end
        cycles++;
        if (cycles == LIMIT)
        begin
            err_count++;
            $display("mismatch at %0t: run did not finish", $time);
            test_done();
        end
    end

    // ==========================================================
    // main sequence
    initial
    begin
        seed = 32'hC778;
        resetn = 1'b0;
        ref_lvl = 1'b0;
        ref_run = 1'b1;
        err_count = 0;
        comparisons = 0;
        strobe_cnt = 0;
        mreset_cnt = 0;
        cycles = 0;
        for (int i = 0; i < 5; i++)
            img[i] = RST_V[i];
        repeat (12) @(posedge sys_clk);
        #1 resetn = 1'b1;
        tick(2);
        check_cfg();
        for (int i = 0; i < 5; i++)
            rd(15'(42 + i));
        // fixed patterns, then random bytes, into every register
        for (int n = 0; n < 8; n++)
        begin
            for (int i = 0; i < 5; i++)
            begin
                v = (n < 4) ? FIX[n] : 8'($random(seed));
                s0 = strobe_cnt;
                wr(15'(42 + i), v);
                check_cfg();
                check_vec(24'(s0 + 1), 24'(strobe_cnt), "load count");
                rd(15'(42 + i));
            end
        end
        // unmapped places and a cut-short frame
        wr(15'h0029, 8'hFF);
        rd(15'h0029);
        rd(15'h002F);
        i_slcr_host_model.xfer(1'b0, 15'h002C, ~img[2], 20);
        tick(10);
        check_cfg();
        rd(15'h002C);
        // modulator reset on fine word update, unmasked then masked
        wr(15'h002A, 8'h00);
        wr(15'h002B, 8'h01);
        s0 = mreset_cnt;
        wr(15'h0010, 8'($random(seed)));
        check_vec(24'(s0 + 1), 24'(mreset_cnt), "modulator reset count");
        wr(15'h002B, 8'h05);
        s0 = mreset_cnt;
        wr(15'h0010, 8'($random(seed)));
        check_vec(24'(s0), 24'(mreset_cnt), "masked reset count");
        check_cfg();
        // load held back until a reference rise
        wr(15'h002A, 8'h08);
        ref_lvl = 1'b0;
        ref_run = 1'b0;
        s0 = strobe_cnt;
        wr(15'h002D, 8'($random(seed)));
        check_vec(24'(s0), 24'(strobe_cnt), "load before reference");
        ref_lvl = 1'b1;
        tick(4);
        check_vec(24'(s0 + 1), 24'(strobe_cnt), "load after reference");
        check_cfg();
        ref_run = 1'b1;
        rd(15'h002D);
        tick(5);
        test_done();
    end
endmodule
`default_nettype wire
